// >>> logic/gpw_ports.sv
// Notes on behaviour
// [R1] Each port A pin has a wake-up enable bit, 0 off and 1 on.
// [R2] Each port pin has a pull-high enable bit, 0 disconnected and 1 connected.
// [R3] Each port pin has a direction bit, 0 output and 1 input.
// [R4] Unimplemented register bits read as zero and ignore writes.
// [R5] Port B pins 0 to 3 become open drain when control bits 7 to 4 are set.
// [R6] Reset sets every data and direction bit to 1, so all pins start as inputs.
// [R7] Single-bit set and clear read the whole port, change one bit and write it all back.
// [R8] In SLEEP or IDLE a falling edge on a wake-enabled port A pin wakes the device.
// [R9] Direction registers take both byte writes and single-bit set or clear.
// [R10] Reading an output pin returns the output latch, not the pin level.
// [R11] Output data stays latched until rewritten, while input reads sample the live pin.
// [R12] A pull-high acts only while its pin is an input.
// [R13] Port A wake inputs are synchronised and checked for a falling edge.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
module gpw_ports (
    input  wire  logic                        CLK_SYS,         // System clock.
    input  wire  logic                        RST,             // Synchronous reset.
    input  wire  logic [gpw_pkg::ADDR_W-1:0]  AVS_ADDRESS,     // Byte address.
    input  wire  logic                        AVS_READ,        // Read request.
    input  wire  logic                        AVS_WRITE,       // Write request.
    input  wire  logic [gpw_pkg::DATA_W-1:0]  AVS_WRITEDATA,   // Write data.
    input  wire  logic [3:0]                  AVS_BYTEENABLE,  // Byte lanes.
    output logic       [gpw_pkg::DATA_W-1:0]  AVS_READDATA,    // Read data.
    output logic                              AVS_WAITREQUEST, // Stall.
    input  wire  logic [7:0]                  PA_IN,           // Port A pin levels.
    output logic       [7:0]                  PA_OUT,          // Port A drive values.
    output logic       [7:0]                  PA_OE,           // Port A drive enables.
    output logic       [7:0]                  PA_PULL,         // Port A pull-high on.
    input  wire  logic [7:0]                  PB_IN,           // Port B pin levels.
    output logic       [7:0]                  PB_OUT,          // Port B drive values.
    output logic       [7:0]                  PB_OE,           // Port B drive enables.
    output logic       [7:0]                  PB_PULL,         // Port B pull-high on.
    input  wire  logic [7:0]                  PC_IN,           // Port C pin levels.
    output logic       [7:0]                  PC_OUT,          // Port C drive values.
    output logic       [7:0]                  PC_OE,           // Port C drive enables.
    output logic       [7:0]                  PC_PULL,         // Port C pull-high on.
    input  wire  logic [1:0]                  PD_IN,           // Port D pin levels.
    output logic       [1:0]                  PD_OUT,          // Port D drive values.
    output logic       [1:0]                  PD_OE,           // Port D drive enables.
    output logic       [1:0]                  PD_PULL,         // Port D pull-high on.
    input  wire  logic                        LOW_POWER,       // Device in SLEEP or IDLE.
    output logic                              WAKE,            // Wake-up pulse.
    output logic                              IRQ              // Level interrupt.
);
    import gpw_pkg::*;

    // Software visible state.
    logic [7:0] data_q   [GPW_NPORT];
    logic [7:0] dir_q    [GPW_NPORT];
    logic [7:0] pull_q   [GPW_NPORT];
    logic [7:0] wake_q;
    logic [7:0] misc_q;
    logic [7:0] status_q;
    logic [7:0] irq_en_q;

    // Port A wake synchroniser and edge history.
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_s3;

    // Gathered pin levels and pin driver terms.
    logic [7:0] pin_in   [GPW_NPORT];
    logic [7:0] od_w     [GPW_NPORT];
    logic [7:0] out_w    [GPW_NPORT];
    logic [7:0] oe_w     [GPW_NPORT];
    logic [7:0] pullon_w [GPW_NPORT];

    // Bus decode.
    wire logic       req;
    wire logic       wr_fire;
    wire logic       word_ok;
    wire logic       in_ports;
    wire logic [1:0] a_port;
    wire logic [1:0] a_kind;
    wire logic       is_bitop;
    wire logic       is_clear;
    wire logic       is_misc;
    wire logic       is_enable;

    // Bit operation fields and result.
    wire logic [2:0] b_bit;
    wire logic [1:0] b_port;
    wire logic [1:0] b_kind;
    wire logic       b_val;
    wire logic [7:0] b_cur;
    wire logic [7:0] b_sel;
    wire logic [7:0] b_mod;

    // Effective register write after merging byte writes and bit operations.
    wire logic       e_wr;
    wire logic [1:0] e_port;
    wire logic [1:0] e_kind;
    wire logic [7:0] e_val;
    wire logic [7:0] e_mask;

    // Read path, wake events and next status.
    wire logic [7:0] rd_byte;
    wire logic [7:0] fall;
    wire logic [7:0] clr;
    wire logic [7:0] next_status;

    // Readback of one port register; data reads mix latch and live pins.
    function automatic logic [7:0] read_reg(input logic [1:0] p, input logic [1:0] k);
        logic [7:0] v;
        v = 8'h00;
        case (k)
            KIND_DATA: v = (dir_q[p] & pin_in[p]) | (~dir_q[p] & data_q[p]); // [R10] [R11]
            KIND_DIR:  v = dir_q[p];
            KIND_PULL: v = pull_q[p];
            KIND_WAKE: v = (p == PORT_A) ? wake_q : 8'h00;
            default:   v = 8'h00;
        endcase
        return v & PORT_MASK[p]; // [R4]
    endfunction

    // Pin levels gathered into one array, port D padded with zeros.
    assign pin_in[0] = PA_IN;
    assign pin_in[1] = PB_IN;
    assign pin_in[2] = PC_IN;
    assign pin_in[3] = {6'h00, PD_IN};

    // Open-drain selects exist on port B bits 3 to 0 only.
    assign od_w[0] = 8'h00;
    assign od_w[1] = {4'h0, misc_q[ODE_LSB +: ODE_W]}; // [R5]
    assign od_w[2] = 8'h00;
    assign od_w[3] = 8'h00;

    // Driver terms per port: an open-drain pin only drives while its latch is low.
    genvar gp;
    generate
        for (gp = 0; gp < GPW_NPORT; gp++) begin : g_pin
            assign out_w[gp]    = data_q[gp] & PORT_MASK[gp];
            assign oe_w[gp]     = ~dir_q[gp] & ~(od_w[gp] & data_q[gp])
                                  & PORT_MASK[gp]; // [R3] [R5]
            assign pullon_w[gp] = pull_q[gp] & dir_q[gp] & PORT_MASK[gp]; // [R2] [R12]
        end
    endgenerate

    // Avalon decode; a write takes effect only at the edge where waitrequest is low.
    assign req       = AVS_READ | AVS_WRITE;
    assign wr_fire   = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
    assign word_ok   = (AVS_ADDRESS[1:0] == 2'h0);
    assign in_ports  = (AVS_ADDRESS < OFS_PORT_LIMIT) & word_ok;
    assign a_port    = AVS_ADDRESS[5:4];
    assign a_kind    = AVS_ADDRESS[3:2];
    assign is_bitop  = wr_fire & (AVS_ADDRESS == OFS_BITOP);
    assign is_clear  = wr_fire & (AVS_ADDRESS == OFS_CLEAR);
    assign is_misc   = wr_fire & (AVS_ADDRESS == OFS_MISC);
    assign is_enable = wr_fire & (AVS_ADDRESS == OFS_ENABLE);

    // Bit set or clear: read the whole register, change one bit, write it all back.
    assign b_bit = AVS_WRITEDATA[BOP_BIT_LSB +: 3];
    assign b_port = AVS_WRITEDATA[BOP_PORT_LSB +: 2];
    assign b_kind = AVS_WRITEDATA[BOP_KIND_LSB +: 2];
    assign b_val = AVS_WRITEDATA[BOP_VAL_POS];
    assign b_cur = read_reg(b_port, b_kind); // [R7]
    assign b_sel = 8'h01 << b_bit;
    assign b_mod = b_val ? (b_cur | b_sel) : (b_cur & ~b_sel); // [R7] [R9]

    // Byte writes and bit operations share one write path into the port registers.
    assign e_wr   = is_bitop | (wr_fire & in_ports); // [R9]
    assign e_port = is_bitop ? b_port : a_port;
    assign e_kind = is_bitop ? b_kind : a_kind;
    assign e_val  = is_bitop ? b_mod : AVS_WRITEDATA[7:0];
    assign e_mask = PORT_MASK[e_port]; // [R4]

    // Read multiplexer; clear and bit operation words read as zero.
    assign rd_byte = in_ports                  ? read_reg(a_port, a_kind) :
                     (AVS_ADDRESS == OFS_MISC)   ? misc_q :
                     (AVS_ADDRESS == OFS_STATUS) ? status_q :
                     (AVS_ADDRESS == OFS_ENABLE) ? irq_en_q :
                                                   8'h00;

    // Falling edges seen past the synchroniser on wake-enabled port A pins.
    assign fall = pa_s3 & ~pa_s2 & wake_q; // [R1] [R13]

    // A wake event arriving with a clear keeps its status bit set.
    assign clr         = is_clear ? AVS_WRITEDATA[7:0] : 8'h00;
    assign next_status = (status_q & ~clr) | fall;

    // Bus handshake: one wait cycle, then read data and release for one cycle.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
        end else if (req & AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= {24'h00_0000, rd_byte};
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // Port registers; unimplemented bits are masked off on every write.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int p = 0; p < GPW_NPORT; p++) begin
                data_q[p] <= RST_DATA; // [R6]
                dir_q[p]  <= RST_DIR; // [R6]
                pull_q[p] <= RST_PULL;
            end
            wake_q <= RST_WAKE;
        end else if (e_wr) begin
            case (e_kind)
                KIND_DATA: data_q[e_port] <= e_val & e_mask; // [R11]
                KIND_DIR:  dir_q[e_port]  <= e_val & e_mask; // [R3] [R9]
                KIND_PULL: pull_q[e_port] <= e_val & e_mask; // [R2]
                KIND_WAKE: begin
                    if (e_port == PORT_A) begin
                        wake_q <= e_val; // [R1]
                    end
                end
                default: wake_q <= wake_q;
            endcase
        end
    end

    // Control register; bits 3 and 2 stay zero.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            misc_q <= RST_MISC;
        end else if (is_misc) begin
            misc_q <= AVS_WRITEDATA[7:0] & MISC_MASK; // [R4] [R5]
        end
    end

    // Interrupt status and enable.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            status_q <= RST_IRQ;
            irq_en_q <= RST_IRQ;
        end else begin
            status_q <= next_status;
            if (is_enable) begin
                irq_en_q <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // Port A synchroniser; the first stage feeds only the second.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pa_s1 <= 8'hFF;
            pa_s2 <= 8'hFF;
            pa_s3 <= 8'hFF;
        end else begin
            pa_s1 <= PA_IN; // [R13]
            pa_s2 <= pa_s1;
            pa_s3 <= pa_s2;
        end
    end

    // Wake pulse and interrupt level, both registered.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            WAKE <= 1'b0;
            IRQ  <= 1'b0;
        end else begin
            WAKE <= LOW_POWER & (|fall); // [R8]
            IRQ  <= |(status_q & irq_en_q);
        end
    end

    // Registered pin drivers; after reset all pins are undriven inputs.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PA_OUT  <= 8'hFF;
            PA_OE   <= 8'h00;
            PA_PULL <= 8'h00;
            PB_OUT  <= 8'hFF;
            PB_OE   <= 8'h00;
            PB_PULL <= 8'h00;
            PC_OUT  <= 8'hFF;
            PC_OE   <= 8'h00;
            PC_PULL <= 8'h00;
            PD_OUT  <= 2'h3;
            PD_OE   <= 2'h0;
            PD_PULL <= 2'h0;
        end else begin
            PA_OUT  <= out_w[0];
            PA_OE   <= oe_w[0];
            PA_PULL <= pullon_w[0];
            PB_OUT  <= out_w[1];
            PB_OE   <= oe_w[1];
            PB_PULL <= pullon_w[1];
            PC_OUT  <= out_w[2];
            PC_OE   <= oe_w[2];
            PC_PULL <= pullon_w[2];
            PD_OUT  <= out_w[3][1:0];
            PD_OE   <= oe_w[3][1:0];
            PD_PULL <= pullon_w[3][1:0];
        end
    end

endmodule

// >>> logic/gpw_pkg.sv
package gpw_pkg;

    // Bus geometry.
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int GPW_NPORT = 4;

    // Register kinds within one port block of four words.
    localparam logic [1:0] KIND_DATA = 2'h0;
    localparam logic [1:0] KIND_DIR  = 2'h1;
    localparam logic [1:0] KIND_PULL = 2'h2;
    localparam logic [1:0] KIND_WAKE = 2'h3;

    // Port blocks sit at 0x00, 0x10, 0x20 and 0x30, one word per kind.
    localparam logic [ADDR_W-1:0] OFS_PORT_LIMIT = 7'h40;
    localparam logic [ADDR_W-1:0] OFS_MISC       = 7'h40;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 7'h44;
    localparam logic [ADDR_W-1:0] OFS_CLEAR      = 7'h48;
    localparam logic [ADDR_W-1:0] OFS_ENABLE     = 7'h4C;
    localparam logic [ADDR_W-1:0] OFS_BITOP      = 7'h50;

    // Implemented bits of each port: A, B and C are eight wide, D is two wide.
    localparam logic [7:0] PORT_MASK [GPW_NPORT] = '{8'hFF, 8'hFF, 8'hFF, 8'h03};

    // Reset values.
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_DIR  = 8'hFF;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_WAKE = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h00;
    localparam logic [7:0] RST_IRQ  = 8'h00;

    // Control register layout.
    localparam logic [7:0] MISC_MASK = 8'hF3;
    localparam int ODE_LSB = 4;
    localparam int ODE_W   = 4;

    // Bit operation command layout.
    localparam int BOP_BIT_LSB  = 0;
    localparam int BOP_PORT_LSB = 3;
    localparam int BOP_KIND_LSB = 5;
    localparam int BOP_VAL_POS  = 7;

    // Port indices of the port with wake-up features (A) and the port with open-drain features (B).
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;

endpackage

// >>> tb/gpw_properties.sv
module gpw_checker (
    // Pin controls only move two edges after an accepted write.
    input wire logic        CLK_SYS,         // Clock.
    input wire logic        RST,             // Reset.
    input wire logic        AVS_READ,        // Read.
    input wire logic        AVS_WRITE,       // Write.
    input wire logic [31:0] AVS_READDATA,    // Read data.
    input wire logic        AVS_WAITREQUEST, // Stall.
    input wire logic [7:0]  PA_IN,           // Port A pins.
    input wire logic [7:0]  PA_OUT,          // Port A drive.
    input wire logic [7:0]  PA_OE,           // Port A enable.
    input wire logic [7:0]  PA_PULL,         // Port A pull.
    input wire logic [7:0]  PB_OUT,          // Port B drive.
    input wire logic [7:0]  PB_OE,           // Port B enable.
    input wire logic [7:0]  PB_PULL,         // Port B pull.
    input wire logic        LOW_POWER,       // Low power.
    input wire logic        WAKE,            // Wake pulse.
    input wire logic        IRQ              // Interrupt.
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dcb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [7:0] pa_q;
    logic [3:0] since;
    // Ages the latest falling edge seen on any port A pin.
    always_ff @(posedge CLK_SYS) begin
        pa_q <= PA_IN;
        if (RST) since <= 4'hF;
        else if ((pa_q & ~PA_IN) != 8'h00) since <= 4'h0;
        else if (since != 4'hF) since <= since + 4'h1;
    end
    AST_REQ_TAKEN: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered after one cycle");
    AST_ONE_WAIT: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    AST_RST_OUT: assert property ($fell(RST) |-> PA_OUT == 8'hFF && PB_OUT == 8'hFF
        && {PA_OE, PB_OE, PA_PULL, PB_PULL} == 32'h0000_0000 && AVS_WAITREQUEST && !IRQ && !WAKE)
        else $error("outputs not at reset values");
    AST_HIGH_ZERO: assert property (AVS_READDATA[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    AST_PULL_IN: assert property (({PA_PULL, PB_PULL} & {PA_OE, PB_OE}) == 16'h0000)
        else $error("pull-high on a driven pin");
    AST_OUT_HOLD: assert property ($changed({PA_OUT, PA_OE, PA_PULL, PB_OUT, PB_OE, PB_PULL})
        |-> $past(AVS_WRITE && !AVS_WAITREQUEST, 2)) else $error("pin controls changed without write");
    AST_WAKE_LP: assert property (WAKE |-> $past(LOW_POWER))
        else $error("wake outside low power");
    AST_WAKE_EDGE: assert property (WAKE |-> since <= 4'h6)
        else $error("wake without a recent falling edge");
    COV_WAKE: cover property (WAKE);
    COV_IRQ: cover property ($rose(IRQ));
    COV_WRITE: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule

// >>> tb/gpw_pin_model.sv
module gpw_pin_model #(
    parameter int W = 8
) (
    input wire logic         clk,    // Clock.
    input wire logic [W-1:0] out,    // Device drive value.
    input wire logic [W-1:0] oe,     // Device drive enable.
    input wire logic [W-1:0] pull,   // Device pull-high.
    input wire logic [W-1:0] ext,    // Outside drive value.
    input wire logic [W-1:0] ext_en, // Outside drive enable.
    output logic     [W-1:0] lvl     // Pin level.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [W-1:0] last;
    // The device wins where it drives; an undriven pin takes its pull or flips each cycle.
    assign lvl = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pull | ~last));
    // Keeps the level so that a floating pin without pull-high never repeats it.
    always_ff @(posedge clk) last <= lvl;
endmodule

// >>> tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import gpw_pkg::*;
    logic        CLK_SYS, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, LOW_POWER, WAKE, IRQ;
    logic [6:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [3:0]  AVS_BYTEENABLE;
    logic [7:0]  PA_IN, PA_OUT, PA_OE, PA_PULL, PB_IN, PB_OUT, PB_OE, PB_PULL;
    logic [7:0]  PC_IN, PC_OUT, PC_OE, PC_PULL, misc, ext [4], ee [4], ov [4], ev [4], pv [4];
    logic [1:0]  PD_IN, PD_OUT, PD_OE, PD_PULL;
    logic [7:0]  sh [4][4];
    int          mismatches, n_compared, cyc;
    // Per-port views of the pin controls.
    assign ov = '{PA_OUT, PB_OUT, PC_OUT, {6'h00, PD_OUT}};
    assign ev = '{PA_OE, PB_OE, PC_OE, {6'h00, PD_OE}};
    assign pv = '{PA_PULL, PB_PULL, PC_PULL, {6'h00, PD_PULL}};
    gpw_ports DUT (.CLK_SYS, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .PA_IN, .PA_OUT, .PA_OE, .PA_PULL,
        .PB_IN, .PB_OUT, .PB_OE, .PB_PULL, .PC_IN, .PC_OUT, .PC_OE, .PC_PULL, .PD_IN, .PD_OUT,
        .PD_OE, .PD_PULL, .LOW_POWER, .WAKE, .IRQ);
    gpw_pin_model u_pa (.clk(CLK_SYS), .out(PA_OUT), .oe(PA_OE), .pull(PA_PULL), .ext(ext[0]),
        .ext_en(ee[0]), .lvl(PA_IN));
    gpw_pin_model u_pb (.clk(CLK_SYS), .out(PB_OUT), .oe(PB_OE), .pull(PB_PULL), .ext(ext[1]),
        .ext_en(ee[1]), .lvl(PB_IN));
    gpw_pin_model u_pc (.clk(CLK_SYS), .out(PC_OUT), .oe(PC_OE), .pull(PC_PULL), .ext(ext[2]),
        .ext_en(ee[2]), .lvl(PC_IN));
    gpw_pin_model #(.W(2)) u_pd (.clk(CLK_SYS), .out(PD_OUT), .oe(PD_OE), .pull(PD_PULL),
        .ext(ext[3][1:0]), .ext_en(ee[3][1:0]), .lvl(PD_IN));
    // Clock and hang guard.
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One bus access, held until the edge that sees waitrequest low.
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        AVS_READ <= !w;
        AVS_WRITE <= w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h00_0000, d};
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
        if (n >= 20) mismatches++;
        q = AVS_READDATA;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
        AVS_WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // Expected read value: live pins for inputs, latch for outputs.
    function automatic logic [7:0] erd(int p, int k);
        if (k == 0) return ((sh[p][1] & (ext[p] | ~ee[p])) | (~sh[p][1] & sh[p][0])) & PORT_MASK[p];
        return sh[p][k];
    endfunction
    function automatic void wreg(int p, int k, logic [7:0] d);
        sh[p][k] = (k == 3 && p != 0) ? 8'h00 : d & PORT_MASK[p];
    endfunction
    // Lets some pulled inputs float, then reads back everything of one port.
    task automatic check_port(int p);
        logic [31:0] q;
        logic [7:0]  od;
        od = (p == 1) ? {4'h0, misc[7:4]} : 8'h00;
        ee[p] <= ~(8'($urandom) & sh[p][2] & sh[p][1]);
        repeat (3) @(posedge CLK_SYS);
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, 7'(p * 16 + k * 4), 8'h00, q);
            chk(q, erd(p, k));
        end
        acc(1'b0, 7'h54 + 7'(p * 4), 8'h00, q);
        chk(q, 0);
        acc(1'b0, OFS_MISC, 8'h00, q);
        chk(q, misc);
        chk(ov[p], sh[p][0]);
        chk(ev[p], ~sh[p][1] & ~(od & sh[p][0]) & PORT_MASK[p]);
        chk(pv[p], sh[p][2] & sh[p][1]);
        AVS_READ <= 1'b0;
        ee[p] <= 8'hFF;
        @(posedge CLK_SYS);
    endtask
    // Reset, random traffic, then the wake and interrupt sequence.
    initial begin
        logic [7:0]  d, base, nv;
        logic [31:0] q;
        int          p, k, b;
        {RST, AVS_READ, AVS_WRITE, LOW_POWER} = 4'h8;
        AVS_ADDRESS = 7'h00;
        AVS_WRITEDATA = 32'h0000_0000;
        AVS_BYTEENABLE = 4'hF;
        ext = '{4{8'hFF}};
        ee = '{4{8'hFF}};
        misc = 8'h00;
        for (int i = 0; i < 4; i++) sh[i] = '{PORT_MASK[i], PORT_MASK[i], 8'h00, 8'h00};
        void'($urandom(56));
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        for (int i = 0; i < 4; i++) check_port(i);
        repeat (40) begin
            p = $urandom % 4;
            k = $urandom % 4;
            d = 8'($urandom);
            b = $urandom % 8;
            case ($urandom % 4)
                0, 1: begin
                    wr(7'(p * 16 + k * 4), d);
                    wreg(p, k, d);
                end
                2: begin
                    base = (k == 0) ? erd(p, 0) : sh[p][k];
                    nv = d[7] ? base | (8'h01 << b) : base & ~(8'h01 << b);
                    wr(OFS_BITOP, {d[7], 2'(k), 2'(p), 3'(b)});
                    wreg(p, k, nv);
                end
                default: if (k == 0) begin
                    wr(OFS_MISC, d);
                    misc = d & MISC_MASK;
                end else ext[p] <= d;
            endcase
            check_port(p);
        end
        wr(7'h04, 8'hFF);
        wr(7'h0C, 8'h03);
        ext[0] <= 8'hFF;
        wr(OFS_CLEAR, 8'hFF);
        wr(OFS_ENABLE, 8'h01);
        LOW_POWER <= 1'b1;
        ext[0] <= 8'hFE;
        q = 0;
        repeat (10) begin
            @(posedge CLK_SYS);
            if (WAKE === 1'b1) q++;
        end
        chk(q, 1);
        acc(1'b0, OFS_STATUS, 8'h00, q);
        chk(q, 1);
        chk(IRQ, 1'b1);
        wr(OFS_ENABLE, 8'h00);
        @(posedge CLK_SYS);
        chk(IRQ, 1'b0);
        wr(OFS_ENABLE, 8'h01);
        @(posedge CLK_SYS);
        chk(IRQ, 1'b1);
        wr(OFS_CLEAR, 8'h01);
        ext[0] <= 8'hFA;
        repeat (6) @(posedge CLK_SYS);
        chk(IRQ, 1'b0);
        acc(1'b0, OFS_STATUS, 8'h00, q);
        chk(q, 0);
        wrap_up();
    end
endmodule
bind gpw_ports gpw_checker u_chk (.CLK_SYS, .RST, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
    .AVS_WAITREQUEST, .PA_IN, .PA_OUT, .PA_OE, .PA_PULL, .PB_OUT, .PB_OE, .PB_PULL,
    .LOW_POWER, .WAKE, .IRQ);
